// file: handler_sva.sv
// Port checks for the supplemental function tag handler
`timescale 1ns/1ps
`default_nettype none
module handler_sva #(
   parameter int NUM_FREEZE = 4
) (
   // Clock and reset
   input wire logic clock_in,
   input wire logic srst_in,
   // Register bus
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   // Header and payload
   input wire logic pic_start_in,
   input wire logic freeze_release_in,
   input wire logic [2:0] source_format_in,
   input wire logic payload_valid_in,
   // Results
   input wire logic [NUM_FREEZE-1:0] freeze_active_out,
   input wire logic snap_valid_out,
   input wire logic protocol_error_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (srst_in);
   logic [2:0] fmt_q;
   logic seen_q;
   // Format of the previous header, to spot a change
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         fmt_q <= 3'h0;
         seen_q <= 1'b0;
      end else if (pic_start_in) begin
         fmt_q <= source_format_in;
         seen_q <= 1'b1;
      end
   end
   sequence access_begin;
      psel_in && $rose(penable_in);
   endsequence
   sequence one_wait;
      !pready_out ##1 pready_out;
   endsequence
   apb_wait_a: assert property (access_begin |-> one_wait)
      else $error("ready not in second access cycle");
   ready_pulse_a: assert property (pready_out |=> !pready_out)
      else $error("ready longer than one cycle");
   idle_data_a: assert property (!pready_out |-> prdata_out == 32'h0)
      else $error("read data outside ready cycle");
   error_ready_a: assert property (pslverr_out |-> pready_out)
      else $error("slave error without ready");
   release_bit_a: assert property (pic_start_in && freeze_release_in |=> freeze_active_out == '0)
      else $error("release bit left a freeze active");
   format_cancel_a: assert property (
      pic_start_in && seen_q && source_format_in != fmt_q |=> freeze_active_out == '0)
      else $error("format change left a freeze active");
   freeze_rise_a: assert property (
      (freeze_active_out & ~$past(freeze_active_out)) != '0 |-> $past(payload_valid_in, 3))
      else $error("freeze opened without payload");
   snap_pulse_a: assert property (snap_valid_out |=> !snap_valid_out)
      else $error("snapshot strobe too long");
   error_pulse_a: assert property (protocol_error_out |=> !protocol_error_out)
      else $error("error strobe too long");
endmodule
bind picture_sei_freeze_tag_handler handler_sva #(.NUM_FREEZE(NUM_FREEZE)) u_handler_sva (.clock_in(clock_in),
   .srst_in(srst_in), .psel_in(psel_in), .penable_in(penable_in), .prdata_out(prdata_out), .pready_out(pready_out),
   .pslverr_out(pslverr_out), .pic_start_in(pic_start_in), .freeze_release_in(freeze_release_in),
   .source_format_in(source_format_in), .payload_valid_in(payload_valid_in), .freeze_active_out(freeze_active_out),
   .snap_valid_out(snap_valid_out), .protocol_error_out(protocol_error_out));
`default_nettype wire

// file: lapse_timer.sv
// Picture and elapsed-time counters for one freeze or segment slot
`timescale 1ns/1ps
`default_nettype none
module lapse_timer #(
   parameter int PIC_LIMIT = 5,
   parameter int TICK_LIMIT = 150
) (
   // Clock and reset
   input wire logic clock_in,
   input wire logic srst_in,
   // Control
   input wire logic restart_in,
   input wire logic pic_tick_in,
   input wire logic [7:0] tr_delta_in,
   // Status
   output logic expired_out
);
   localparam int PW = $clog2(PIC_LIMIT + 1);
   localparam int TW = $clog2(TICK_LIMIT + 256);

   logic [PW-1:0] pics_q;
   logic [TW-1:0] ticks_q;
   logic pics_done;
   logic ticks_done;

   if (PIC_LIMIT < 1 || TICK_LIMIT < 1) begin : g_bad
      $error("lapse_timer limits must be positive");
   end

   assign pics_done = pics_q >= PW'(PIC_LIMIT);
   assign ticks_done = ticks_q >= TW'(TICK_LIMIT);
   assign expired_out = pics_done && ticks_done;

   always_ff @(posedge clock_in) begin
      if (srst_in || restart_in) begin
         pics_q <= '0;
         ticks_q <= '0;
      end else if (pic_tick_in) begin
         if (!pics_done) begin
            pics_q <= pics_q + PW'(1);
         end
         if (!ticks_done) begin
            ticks_q <= ticks_q + TW'(tr_delta_in);
         end
      end
   end
endmodule
`default_nettype wire

// file: payload_source.sv
// Bitstream parser model: picture headers and supplemental octets
`timescale 1ns/1ps
`default_nettype none
module payload_source (
   // Clock
   input wire logic clock_in,
   // Header events and payload
   output logic pic_start_out,
   output logic release_out,
   output logic [2:0] format_out,
   output logic [7:0] tr_out,
   output logic valid_out,
   output logic [7:0] octet_out
);
   initial begin
      pic_start_out = 1'b0;
      release_out = 1'b0;
      format_out = 3'h0;
      tr_out = 8'h00;
      valid_out = 1'b0;
      octet_out = 8'h00;
   end
   // Header fields are only meaningful with the strobe
   task automatic pic(input logic rel, input logic [2:0] fmt, input logic [7:0] tr);
      @(posedge clock_in);
      pic_start_out <= 1'b1;
      release_out <= rel;
      format_out <= fmt;
      tr_out <= tr;
      @(posedge clock_in);
      pic_start_out <= 1'b0;
      release_out <= ~rel;
      format_out <= ~fmt;
      tr_out <= ~tr;
      repeat (2) @(posedge clock_in);
   endtask
   // Type and count nibbles, then count octets from the top of p
   task automatic fn(input logic [3:0] ty, input logic [3:0] cnt, input logic [63:0] p);
      @(posedge clock_in);
      valid_out <= 1'b1;
      octet_out <= {ty, cnt};
      for (int i = 0; i < cnt; i++) begin
         @(posedge clock_in);
         octet_out <= p[63-8*i -: 8];
      end
      @(posedge clock_in);
      valid_out <= 1'b0;
      octet_out <= ~octet_out;
      repeat (4) @(posedge clock_in);
   endtask
endmodule
`default_nettype wire

// file: picture_sei_freeze_tag_handler.sv
// Freeze, snapshot and segment tag handler for supplemental picture functions
`timescale 1ns/1ps
`default_nettype none
module picture_sei_freeze_tag_handler #(
   parameter int NUM_FREEZE = 4,
   parameter int NUM_TSEG = 4,
   parameter int NUM_RSEG = 4
) (
   // Clock and reset
   input wire logic clock_in,
   input wire logic srst_in,
   // APB slave
   input wire logic [7:0] paddr_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Picture header events and supplemental payload from the parser
   input wire logic pic_start_in,
   input wire logic freeze_release_in,
   input wire logic [2:0] source_format_in,
   input wire logic [7:0] temporal_ref_in,
   input wire logic payload_valid_in,
   input wire logic [7:0] payload_octet_in,
   // Display compositor
   output logic [NUM_FREEZE-1:0] freeze_active_out,
   output logic [NUM_FREEZE*32-1:0] freeze_disp_region_out,
   output logic [NUM_FREEZE*32-1:0] freeze_dec_region_out,
   // Tagging consumer
   output logic snap_valid_out,
   output logic snap_partial_out,
   output logic [31:0] snap_id_out,
   output logic [31:0] snap_region_out,
   output logic [NUM_TSEG-1:0] tseg_active_out,
   output logic [NUM_RSEG-1:0] rseg_active_out,
   output logic [(NUM_TSEG+NUM_RSEG)*32-1:0] seg_id_out,
   output logic protocol_error_out
);
   import sei_tag_pkg::*;

   localparam int NS = NUM_FREEZE + NUM_TSEG + NUM_RSEG;
   localparam logic [NS-1:0] FMASK = NS'((64'h1 << NUM_FREEZE) - 64'h1);
   localparam logic [NS-1:0] TMASK = NS'(((64'h1 << NUM_TSEG) - 64'h1) << NUM_FREEZE);
   localparam logic [NS-1:0] RMASK = ~(FMASK | TMASK);

   if (NUM_FREEZE < 1 || NUM_TSEG < 1 || NUM_RSEG < 1 || NS > 32) begin : g_bad
      $error("slot counts must be at least one and at most 32 in total");
   end

   // Region overlap, both rectangles in eight-pixel units
   function automatic logic overlaps(input logic [31:0] a, input logic [31:0] b);
      logic [8:0] ax_end;
      logic [8:0] bx_end;
      logic [8:0] ay_end;
      logic [8:0] by_end;
      ax_end = {1'b0, a[31:24]} + {1'b0, a[15:8]};
      bx_end = {1'b0, b[31:24]} + {1'b0, b[15:8]};
      ay_end = {1'b0, a[23:16]} + {1'b0, a[7:0]};
      by_end = {1'b0, b[23:16]} + {1'b0, b[7:0]};
      return ({1'b0, a[31:24]} < bx_end) && ({1'b0, b[31:24]} < ax_end) &&
             ({1'b0, a[23:16]} < by_end) && ({1'b0, b[23:16]} < ay_end);
   endfunction

   // Fixed parameter count of each handled type; unhandled types return none
   function automatic logic [4:0] fixed_count(input logic [3:0] t);
      unique case (t)
         FN_PART_FREEZE, FN_FREEZE_RELEASE, FN_FULL_SNAP: return {1'b1, CNT_QUAD};
         FN_TSEG_START, FN_TSEG_END, FN_RSEG_START, FN_RSEG_END: return {1'b1, CNT_QUAD};
         FN_RESIZE_FREEZE, FN_PART_SNAP: return {1'b1, CNT_DUAL};
         default: return 5'h0;
      endcase
   endfunction

   // Parser
   logic fn_valid;
   logic [3:0] fn_type;
   logic [3:0] fn_count;
   logic [63:0] fn_param;

   sei_function_parser u_parser (
      .clock_in(clock_in),
      .srst_in(srst_in),
      .pic_start_in(pic_start_in),
      .payload_valid_in(payload_valid_in),
      .payload_octet_in(payload_octet_in),
      .fn_valid_out(fn_valid),
      .fn_type_out(fn_type),
      .fn_count_out(fn_count),
      .fn_param_out(fn_param)
   );

   // Registers
   logic enable_q;
   logic cnt_err_q;
   logic ovf_q;
   logic [2:0] fmt_q;
   logic fmt_seen_q;
   logic [7:0] tr_q;
   logic cur_release_q;
   logic [NS-1:0] active_q;
   logic [31:0] key_q [NS];
   logic [31:0] aux_q [NS];

   // Function decode
   logic [4:0] fc;
   logic handled;
   logic count_ok;
   logic act;
   logic count_err;
   logic [31:0] hi;
   logic [31:0] lo;
   logic is_resize;
   logic is_part;
   logic is_release;
   logic is_tstart;
   logic is_tend;
   logic is_rstart;
   logic is_rend;

   assign fc = fixed_count(fn_type);
   assign handled = fc[4];
   assign count_ok = fn_count == fc[3:0];
   assign act = fn_valid && enable_q && handled && count_ok;
   assign count_err = fn_valid && enable_q && handled && !count_ok;
   assign hi = fn_param[63:32];
   assign lo = fn_param[31:0];
   assign is_resize = act && fn_type == FN_RESIZE_FREEZE;
   assign is_part = act && fn_type == FN_PART_FREEZE;
   assign is_release = act && fn_type == FN_FREEZE_RELEASE;
   assign is_tstart = act && fn_type == FN_TSEG_START;
   assign is_tend = act && fn_type == FN_TSEG_END;
   assign is_rstart = act && fn_type == FN_RSEG_START;
   assign is_rend = act && fn_type == FN_RSEG_END;

   // Picture header events
   logic fmt_change;
   logic [7:0] tr_delta;
   logic apb_wr;
   logic flush;

   assign fmt_change = pic_start_in && fmt_seen_q && source_format_in != fmt_q;
   assign tr_delta = temporal_ref_in - tr_q;

   // Per-slot matching, closing and timing
   logic [NS-1:0] match_v;
   logic [NS-1:0] close_v;
   logic [NS-1:0] restart_v;
   logic [NS-1:0] expired_v;
   logic [NS-1:0] alloc_v;

   for (genvar i = 0; i < NS; i++) begin : g_slot
      logic is_f;
      logic is_t;
      logic is_r;
      logic ov;
      assign is_f = FMASK[i];
      assign is_t = TMASK[i];
      assign is_r = RMASK[i];
      assign ov = active_q[i] && is_f && overlaps(key_q[i], hi);
      assign match_v[i] = active_q[i] && key_q[i] == hi;
      assign restart_v[i] = (is_resize && is_f && match_v[i]) ||
                            (is_part && ov) ||
                            (is_tstart && is_t && match_v[i]) ||
                            (is_rstart && is_r && match_v[i]);
      assign close_v[i] = flush ||
                          (is_release && ov) ||
                          (is_tend && is_t && match_v[i]) ||
                          (is_rend && is_r && match_v[i]) ||
                          (pic_start_in && expired_v[i]) ||
                          (is_f && pic_start_in && (freeze_release_in || fmt_change));

      lapse_timer #(
         .PIC_LIMIT(TIMEOUT_PICTURES),
         .TICK_LIMIT(TIMEOUT_TR_TICKS)
      ) u_timer (
         .clock_in(clock_in),
         .srst_in(srst_in),
         .restart_in(restart_v[i] || alloc_v[i]),
         .pic_tick_in(pic_start_in && active_q[i]),
         .tr_delta_in(tr_delta),
         .expired_out(expired_v[i])
      );

      always_ff @(posedge clock_in) begin
         if (srst_in || close_v[i]) begin
            active_q[i] <= 1'b0;
         end else if (alloc_v[i]) begin
            active_q[i] <= 1'b1;
            key_q[i] <= hi;
            aux_q[i] <= lo;
         end
         if (srst_in) begin
            key_q[i] <= 32'h0;
            aux_q[i] <= 32'h0;
         end
      end
   end

   // Allocation of a free slot for a new freeze or segment
   logic [NS-1:0] gmask;
   logic [NS-1:0] free_g;
   logic [NS-1:0] first_free;
   logic new_req;
   logic overflow;

   assign gmask = is_resize ? FMASK : (is_tstart ? TMASK : (is_rstart ? RMASK : '0));
   assign free_g = ~active_q & gmask;
   assign first_free = free_g & (~free_g + NS'(1));
   // Resizing freeze requested in a picture whose release bit is set is never allocated
   assign new_req = (is_resize && !cur_release_q) || is_tstart || is_rstart;
   assign alloc_v = (new_req && !(|(match_v & gmask))) ? first_free : '0;
   assign overflow = new_req && !(|(match_v & gmask)) && !(|free_g);

   // Picture header tracking
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         fmt_q <= FORMAT_RESET;
         fmt_seen_q <= 1'b0;
         tr_q <= 8'h0;
         cur_release_q <= 1'b0;
      end else if (pic_start_in) begin
         fmt_q <= source_format_in;
         fmt_seen_q <= 1'b1;
         tr_q <= temporal_ref_in;
         cur_release_q <= freeze_release_in;
      end
   end

   // Snapshot and error events
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         snap_valid_out <= 1'b0;
         snap_partial_out <= 1'b0;
         snap_id_out <= 32'h0;
         snap_region_out <= 32'h0;
         protocol_error_out <= 1'b0;
      end else begin
         snap_valid_out <= act && (fn_type == FN_FULL_SNAP || fn_type == FN_PART_SNAP);
         protocol_error_out <= count_err;
         if (act && fn_type == FN_FULL_SNAP) begin
            snap_partial_out <= 1'b0;
            snap_id_out <= hi;
            snap_region_out <= 32'h0;
         end else if (act && fn_type == FN_PART_SNAP) begin
            snap_partial_out <= 1'b1;
            snap_id_out <= hi;
            snap_region_out <= lo;
         end
      end
   end

   // Consumer-facing slot state
   for (genvar f = 0; f < NUM_FREEZE; f++) begin : g_fout
      assign freeze_disp_region_out[f*32 +: 32] = key_q[f];
      assign freeze_dec_region_out[f*32 +: 32] = aux_q[f];
   end
   for (genvar s = 0; s < NUM_TSEG + NUM_RSEG; s++) begin : g_sout
      assign seg_id_out[s*32 +: 32] = key_q[NUM_FREEZE + s];
   end
   assign freeze_active_out = active_q[NUM_FREEZE-1:0];
   assign tseg_active_out = active_q[NUM_FREEZE +: NUM_TSEG];
   assign rseg_active_out = active_q[NUM_FREEZE + NUM_TSEG +: NUM_RSEG];

   // APB slave: answers on the second access cycle
   logic access;
   logic hit;
   logic [31:0] rd_mux;

   assign access = psel_in && penable_in;
   assign apb_wr = access && pready_out && pwrite_in;
   assign flush = apb_wr && paddr_in == ADDR_CTRL && pwdata_in[CTRL_FLUSH_BIT];
   assign hit = paddr_in == ADDR_CTRL || paddr_in == ADDR_STATUS ||
                paddr_in == ADDR_ACTIVE || paddr_in == ADDR_FORMAT;
   assign rd_mux = (paddr_in == ADDR_CTRL) ? 32'(enable_q) :
                   (paddr_in == ADDR_STATUS) ? 32'({ovf_q, cnt_err_q}) :
                   (paddr_in == ADDR_ACTIVE) ? 32'(active_q) :
                   (paddr_in == ADDR_FORMAT) ? 32'({fmt_seen_q, fmt_q}) : 32'h0;

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         pready_out <= 1'b0;
         prdata_out <= 32'h0;
         pslverr_out <= 1'b0;
      end else begin
         pready_out <= access && !pready_out;
         prdata_out <= (access && !pready_out && !pwrite_in) ? rd_mux : 32'h0;
         pslverr_out <= access && !pready_out && !hit;
      end
   end

   // Control and sticky status; a new event wins over a clear
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         enable_q <= CTRL_ENABLE_RESET;
         cnt_err_q <= 1'b0;
         ovf_q <= 1'b0;
      end else begin
         if (apb_wr && paddr_in == ADDR_CTRL) begin
            enable_q <= pwdata_in[CTRL_ENABLE_BIT];
         end
         if (count_err) begin
            cnt_err_q <= 1'b1;
         end else if (apb_wr && paddr_in == ADDR_STATUS && pwdata_in[STATUS_CNT_ERR_BIT]) begin
            cnt_err_q <= 1'b0;
         end
         if (overflow) begin
            ovf_q <= 1'b1;
         end else if (apb_wr && paddr_in == ADDR_STATUS && pwdata_in[STATUS_OVF_BIT]) begin
            ovf_q <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// file: picture_sei_freeze_tag_handler_tb_top.sv
// Self-checking bench for the supplemental function tag handler
`timescale 1ns/1ps
`default_nettype none
module picture_sei_freeze_tag_handler_tb_top;
   import sei_tag_pkg::*;
   logic clock_in = 1'b0;
   logic srst_in = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, snap_id, snap_region, rd;
   logic pready, pslverr, pic, rel, valid, snap_v, snap_p, perr, er;
   logic [2:0] fmt;
   logic [7:0] tr, octet;
   logic [3:0] fa, ta, ra;
   logic [127:0] fdisp, fdec;
   logic [255:0] seg_id;
   logic [2:0] f = 3'h2;
   logic [7:0] t = 8'h00;
   int n_fail = 0;
   int n_checks = 0;
   int n_snaps = 0;
   int n_errs = 0;
   initial forever #20 clock_in = ~clock_in;
   picture_sei_freeze_tag_handler dut (.clock_in(clock_in), .srst_in(srst_in), .paddr_in(paddr), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .pic_start_in(pic), .freeze_release_in(rel), .source_format_in(fmt),
      .temporal_ref_in(tr), .payload_valid_in(valid), .payload_octet_in(octet), .freeze_active_out(fa),
      .freeze_disp_region_out(fdisp), .freeze_dec_region_out(fdec), .snap_valid_out(snap_v),
      .snap_partial_out(snap_p), .snap_id_out(snap_id), .snap_region_out(snap_region), .tseg_active_out(ta),
      .rseg_active_out(ra), .seg_id_out(seg_id), .protocol_error_out(perr));
   payload_source src (.clock_in(clock_in), .pic_start_out(pic), .release_out(rel), .format_out(fmt),
      .tr_out(tr), .valid_out(valid), .octet_out(octet));
   // Strobes are counted so that tests can look later
   always @(posedge clock_in) begin
      if (snap_v === 1'b1) n_snaps <= n_snaps + 1;
      if (perr === 1'b1) n_errs <= n_errs + 1;
   end
   task automatic print_verdict;
      if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string what, input logic [71:0] seen, input logic [71:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clock_in);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_in);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clock_in);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
         chk("apb ready", pready, 1'b1);
         print_verdict();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic act(input int k);
      return k == 0 ? fa[0] : (k == 1 ? ta[0] : ra[0]);
   endfunction
   task automatic step(input int n, input logic [7:0] d);
      repeat (n) begin
         t = t + d;
         src.pic(1'b0, f, t);
      end
   endtask
   // Kind 0 is a resizing freeze, 1 a time segment, 2 a refinement segment
   task automatic start(input int k);
      src.fn(k == 0 ? FN_RESIZE_FREEZE : 4'(FN_TSEG_START + 2 * (k - 1)), k == 0 ? CNT_DUAL : CNT_QUAD,
         64'h01020304_02040608);
   endtask
   initial begin
      repeat (3) @(posedge clock_in);
      srst_in <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, 8'(4 * i), 32'h0);
         chk("reset value", rd, i == 0);
      end
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped read", {er, rd}, {1'b1, 32'h0});
      src.pic(1'b0, f, t);
      start(0);
      chk("freeze regions", {fa, fdisp[31:0], fdec[31:0]}, {4'h1, 64'h01020304_02040608});
      apb(1'b0, ADDR_ACTIVE, 32'h0);
      chk("active bits", rd, 32'h1);
      src.fn(FN_FREEZE_RELEASE, CNT_QUAD, 64'h01020304_00000000);
      chk("released", fa, 4'h0);
      src.fn(FN_RESIZE_FREEZE, CNT_QUAD, 64'h01020304_00000000);
      chk("count error", {fa, n_errs[3:0]}, 8'h01);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("error status", rd[0], 1'b1);
      apb(1'b1, ADDR_STATUS, 32'h1);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("status cleared", rd[0], 1'b0);
      src.fn(FN_FULL_SNAP, CNT_QUAD, 64'hcafe0001_00000000);
      chk("full snap", {n_snaps[3:0], snap_p, snap_id, snap_region}, {5'h02, 64'hcafe0001_00000000});
      src.fn(FN_PART_SNAP, CNT_DUAL, 64'h00000077_05060708);
      chk("part snap", {n_snaps[3:0], snap_p, snap_id, snap_region}, {5'h05, 64'h00000077_05060708});
      apb(1'b1, ADDR_CTRL, 32'h0);
      src.fn(FN_FULL_SNAP, CNT_QUAD, 64'hcafe0002_00000000);
      chk("disabled", n_snaps[3:0], 4'h2);
      apb(1'b1, ADDR_CTRL, 32'h1);
      for (int k = 1; k < 3; k++) begin
         start(k);
         chk("segment open", {act(k), seg_id[128*(k-1) +: 32]}, {1'b1, 32'h01020304});
         src.fn(4'(FN_TSEG_END + 2 * (k - 1)), CNT_QUAD, 64'h01020304_00000000);
         chk("segment closed", act(k), 1'b0);
      end
      // Five distinct freezes for four slots, then a flush of everything
      start(1);
      for (int i = 0; i < 5; i++) begin
         src.fn(FN_RESIZE_FREEZE, CNT_DUAL, {8'(i), 56'h000101_00000202});
      end
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("no free slot", {fa, ta[0], rd}, {5'h1f, 32'h2});
      apb(1'b1, ADDR_CTRL, 32'h3);
      apb(1'b1, ADDR_STATUS, 32'h2);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("flushed", {fa, ta[0], rd}, {5'h00, 32'h0});
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk("flush reads zero", rd, 32'h1);
      for (int k = 0; k < 3; k++) begin
         start(k);
         step(4, 8'd40);
         chk("held by count", act(k), 1'b1);
         step(1, 8'd40);
         if (k == 0) src.fn(FN_PART_FREEZE, CNT_QUAD, 64'h01020304_00000000);
         else start(k);
         step(3, 8'd40);
         chk("extended", act(k), 1'b1);
         step(5, 8'd40);
         chk("lapsed", act(k), 1'b0);
      end
      start(0);
      step(6, 8'd10);
      chk("held by time", fa[0], 1'b1);
      f = 3'h3;
      step(1, 8'd10);
      chk("format change", fa[0], 1'b0);
      start(0);
      step(1, 8'd10);
      chk("held before release", fa[0], 1'b1);
      src.pic(1'b1, f, t);
      chk("release bit", fa[0], 1'b0);
      print_verdict();
   end
endmodule
`default_nettype wire

// file: sei_function_parser.sv
// Splits the supplemental payload octet stream into functions
`timescale 1ns/1ps
`default_nettype none
module sei_function_parser (
   // Clock and reset
   input wire logic clock_in,
   input wire logic srst_in,
   // Payload stream
   input wire logic pic_start_in,
   input wire logic payload_valid_in,
   input wire logic [7:0] payload_octet_in,
   // Decoded function
   output logic fn_valid_out,
   output logic [3:0] fn_type_out,
   output logic [3:0] fn_count_out,
   output logic [63:0] fn_param_out
);
   import sei_tag_pkg::*;

   parse_state_e state_q;
   logic [3:0] rem_q;
   logic [3:0] idx_q;
   logic [63:0] param_q;
   logic [63:0] param_nx;
   logic last_octet;

   assign last_octet = (state_q == PS_PARAM) && (rem_q == 4'h1);

   // Octets past the eighth are skipped
   always_comb begin
      param_nx = param_q;
      if (idx_q < 4'(PARAM_OCTETS)) begin
         param_nx[63 - 8 * idx_q -: 8] = payload_octet_in;
      end
   end

   always_ff @(posedge clock_in) begin
      fn_valid_out <= 1'b0;
      if (srst_in || pic_start_in) begin
         state_q <= PS_HEAD;
         rem_q <= 4'h0;
         idx_q <= 4'h0;
         param_q <= 64'h0;
      end else if (payload_valid_in) begin
         unique case (state_q)
            PS_HEAD: begin
               fn_type_out <= payload_octet_in[7:4];
               fn_count_out <= payload_octet_in[3:0];
               param_q <= 64'h0;
               idx_q <= 4'h0;
               rem_q <= payload_octet_in[3:0];
               if (payload_octet_in[3:0] == CNT_NONE) begin
                  fn_valid_out <= 1'b1;
                  fn_param_out <= 64'h0;
               end else begin
                  state_q <= PS_PARAM;
               end
            end
            PS_PARAM: begin
               param_q <= param_nx;
               idx_q <= idx_q + 4'h1;
               rem_q <= rem_q - 4'h1;
               if (last_octet) begin
                  fn_valid_out <= 1'b1;
                  fn_param_out <= param_nx;
                  state_q <= PS_HEAD;
               end
            end
         endcase
      end
      if (srst_in) begin
         fn_valid_out <= 1'b0;
         fn_type_out <= 4'h0;
         fn_count_out <= 4'h0;
         fn_param_out <= 64'h0;
      end
   end
endmodule
`default_nettype wire

// file: sei_tag_pkg.sv
// Constants shared by the supplemental function tag handler
`default_nettype none
package sei_tag_pkg;
   // Function type codes
   localparam logic [3:0] FN_PART_FREEZE = 4'h3;
   localparam logic [3:0] FN_RESIZE_FREEZE = 4'h4;
   localparam logic [3:0] FN_FREEZE_RELEASE = 4'h5;
   localparam logic [3:0] FN_FULL_SNAP = 4'h6;
   localparam logic [3:0] FN_PART_SNAP = 4'h7;
   localparam logic [3:0] FN_TSEG_START = 4'h8;
   localparam logic [3:0] FN_TSEG_END = 4'h9;
   localparam logic [3:0] FN_RSEG_START = 4'ha;
   localparam logic [3:0] FN_RSEG_END = 4'hb;
   // Fixed parameter octet counts
   localparam logic [3:0] CNT_NONE = 4'h0;
   localparam logic [3:0] CNT_QUAD = 4'h4;
   localparam logic [3:0] CNT_DUAL = 4'h8;
   // Octets kept per function
   localparam int PARAM_OCTETS = 8;
   // Lapse limits; temporal reference ticks per second approximated as 30
   localparam int TIMEOUT_SECONDS = 5;
   localparam int TIMEOUT_PICTURES = 5;
   localparam int TR_TICKS_PER_SECOND = 30;
   localparam int TIMEOUT_TR_TICKS = TIMEOUT_SECONDS * TR_TICKS_PER_SECOND;
   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_ACTIVE = 8'h08;
   localparam logic [7:0] ADDR_FORMAT = 8'h0c;
   // Field positions and reset values
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_FLUSH_BIT = 1;
   localparam int STATUS_CNT_ERR_BIT = 0;
   localparam int STATUS_OVF_BIT = 1;
   localparam int FORMAT_SEEN_BIT = 3;
   localparam logic CTRL_ENABLE_RESET = 1'b1;
   localparam logic [2:0] FORMAT_RESET = 3'h0;
   // Parser states
   typedef enum logic [1:0] {PS_HEAD = 2'b01, PS_PARAM = 2'b10} parse_state_e;
endpackage
`default_nettype wire
